// [core/lcr_pkg.sv]
package lcr_pkg;

  // ****************************************
  // Register map.
  // ****************************************
  localparam int AXI_ADDR_W = 8;
  localparam logic [7:0] CFG_OFS = 8'h00;
  localparam logic [7:0] LUTF_OFS = 8'h04;
  localparam logic [7:0] LUTG_OFS = 8'h08;
  localparam logic [7:0] LUTH_OFS = 8'h0C;
  localparam logic [7:0] STAT_OFS = 8'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // Reset values.
  // ****************************************
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [15:0] LUT_RESET = 16'h0000;
  localparam logic [7:0] LUTH_RESET = 8'h00;
  localparam int CFG_USED_W = 19;

  // ****************************************
  // Timing.
  // ****************************************
  localparam int CLK_MHZ = 20;
  localparam int WRITE_NS = 8;
  localparam int WRITE_RAW = (WRITE_NS * CLK_MHZ) / 1000;
  localparam int WRITE_CYC = (WRITE_RAW < 1) ? 1 : WRITE_RAW;

  // ****************************************
  // Types.
  // ****************************************
  typedef enum logic [1:0] {
    SR_OFF = 2'h0,
    SR_SET = 2'h1,
    SR_RESET = 2'h2
  } lcr_sr_e;

  typedef enum logic [1:0] {
    SRC_F = 2'h0,
    SRC_G = 2'h1,
    SRC_H = 2'h2,
    SRC_DIN = 2'h3
  } lcr_src_e;

  typedef struct packed {
    logic [12:0] spare;
    logic gsr;
    logic ff2_init;
    logic ff1_init;
    lcr_sr_e ff2_sr;
    lcr_sr_e ff1_sr;
    logic ff2_neg;
    logic ff1_neg;
    lcr_src_e ff2_src;
    lcr_src_e ff1_src;
    logic y_sel;
    logic x_sel;
    logic count_en;
    logic carry_en;
    logic mem_32x1;
    logic mem_en;
  } lcr_cfg_s;

endpackage

// [core/lcr_lut_ram.sv]
`timescale 1ns/1ps
module lcr_lut_ram #(
  parameter int ADDR_W = 4
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic load_in,
  input wire logic [(1<<ADDR_W)-1:0] load_data_in,
  input wire logic write_in,
  input wire logic [ADDR_W-1:0] waddr_in,
  input wire logic wdata_in,
  input wire logic [ADDR_W-1:0] raddr_in,
  output logic rdata_out,
  output logic [(1<<ADDR_W)-1:0] contents_out
);
  import lcr_pkg::*;

  logic [(1<<ADDR_W)-1:0] mem_reg;

  // ****************************************
  // Storage: software load, then user bit write on top.
  // ****************************************
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mem_reg <= (1<<ADDR_W)'(LUT_RESET);
    end else if (ce_in) begin
      if (load_in) begin
        mem_reg <= load_data_in;
      end
      if (write_in) begin
        mem_reg[waddr_in] <= wdata_in;
      end
    end
  end

  assign rdata_out = mem_reg[raddr_in];
  assign contents_out = mem_reg;

endmodule

// [core/lcr_cell_ff.sv]
`timescale 1ns/1ps
module lcr_cell_ff (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic tick_in,
  input wire logic cell_ce_in,
  input wire logic d_in,
  input wire logic sr_in,
  input wire lcr_pkg::lcr_sr_e sr_mode_in,
  input wire logic gsr_in,
  input wire logic init_in,
  output logic q_out
);
  import lcr_pkg::*;

  // ****************************************
  // Flip-flop with set/reset priority.
  // ****************************************
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      q_out <= 1'b0;
    end else if (ce_in) begin
      if (gsr_in) begin
        q_out <= init_in;
      end else if (sr_in && sr_mode_in == SR_SET) begin
        q_out <= 1'b1;
      end else if (sr_in && sr_mode_in == SR_RESET) begin
        q_out <= 1'b0;
      end else if (tick_in && cell_ce_in) begin
        q_out <= d_in;
      end
    end
  end

endmodule

// [core/lcr_cell.sv]
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
module lcr_cell (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [3:0] table_f_inputs_in,
  input wire logic [3:0] table_g_inputs_in,
  input wire logic auxiliary_input_in,
  input wire logic high_control_input_in,
  input wire logic low_control_input_in,
  input wire logic set_reset_in,
  input wire logic cell_clk_in,
  input wire logic cell_clock_enable_in,
  input wire logic global_reset_in,
  input wire logic carry_in_in,
  output logic carry_out_out,
  output logic comb_x_out,
  output logic comb_y_out,
  output logic reg_out_first_out,
  output logic reg_out_second_out,
  input wire logic [lcr_pkg::AXI_ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [lcr_pkg::AXI_ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in
);
  import lcr_pkg::*;

  localparam int WR_DLY = WRITE_CYC;

  lcr_cfg_s cfg_reg;
  logic [7:0] luth_reg;
  logic gsr_pulse_reg;
  logic [AXI_ADDR_W-1:0] awaddr_reg;
  logic aw_full_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic w_full_reg;
  logic do_write;
  logic [31:0] wr_merged;
  logic wr_cfg;
  logic wr_lutf;
  logic wr_lutg;
  logic wr_luth;
  logic wr_ok;
  logic [31:0] rd_data;
  logic rd_ok;
  logic [15:0] lutf_q;
  logic [15:0] lutg_q;
  logic cell_clk_prev_reg;
  logic cell_rise;
  logic cell_fall;
  logic user_we;
  logic we_f;
  logic we_g;
  logic wd_f;
  logic wd_g;
  logic f_lut;
  logic g_lut;
  logic f_out;
  logic g_out;
  logic h_out;
  logic h_third;
  logic c_mid;
  logic cnt_mode;
  logic cnt_load;
  logic sr_act;
  logic gsr_all;
  logic d1;
  logic d2;
  logic [7:0] status;

  function automatic logic [31:0] merge_strb(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] strb
  );
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // ****************************************
  // AXI4-Lite write channels.
  // ****************************************
  assign s_axi_awready_out = !aw_full_reg;
  assign s_axi_wready_out = !w_full_reg;
  assign do_write = aw_full_reg && w_full_reg && !s_axi_bvalid_out;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      aw_full_reg <= 1'b0;
      awaddr_reg <= '0;
    end else if (ce_in) begin
      if (s_axi_awvalid_in && !aw_full_reg) begin
        aw_full_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr_in;
      end else if (s_axi_bvalid_out && s_axi_bready_in) begin
        aw_full_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      w_full_reg <= 1'b0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
    end else if (ce_in) begin
      if (s_axi_wvalid_in && !w_full_reg) begin
        w_full_reg <= 1'b1;
        wdata_reg <= s_axi_wdata_in;
        wstrb_reg <= s_axi_wstrb_in;
      end else if (s_axi_bvalid_out && s_axi_bready_in) begin
        w_full_reg <= 1'b0;
      end
    end
  end

  always_comb begin
    wr_cfg = 1'b0;
    wr_lutf = 1'b0;
    wr_lutg = 1'b0;
    wr_luth = 1'b0;
    wr_ok = 1'b1;
    wr_merged = 32'h0000_0000;
    unique case (awaddr_reg)
      CFG_OFS: begin
        wr_cfg = do_write;
        wr_merged = merge_strb(32'(cfg_reg), wdata_reg, wstrb_reg);
      end
      LUTF_OFS: begin
        wr_lutf = do_write;
        wr_merged = merge_strb({16'h0000, lutf_q}, wdata_reg, wstrb_reg);
      end
      LUTG_OFS: begin
        wr_lutg = do_write;
        wr_merged = merge_strb({16'h0000, lutg_q}, wdata_reg, wstrb_reg);
      end
      LUTH_OFS: begin
        wr_luth = do_write;
        wr_merged = merge_strb({24'h00_0000, luth_reg}, wdata_reg, wstrb_reg);
      end
      default: begin
        wr_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= RESP_OKAY;
    end else if (ce_in) begin
      if (do_write) begin
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
      end
    end
  end

  // ****************************************
  // Configuration and third table registers.
  // ****************************************
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cfg_reg <= CFG_RESET;
      gsr_pulse_reg <= 1'b0;
    end else if (ce_in) begin
      gsr_pulse_reg <= 1'b0;
      if (wr_cfg) begin
        cfg_reg <= lcr_cfg_s'({13'h0000, 1'b0, wr_merged[CFG_USED_W-2:0]});
        gsr_pulse_reg <= wr_merged[CFG_USED_W-1];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      luth_reg <= LUTH_RESET;
    end else if (ce_in && wr_luth) begin
      luth_reg <= wr_merged[7:0];
    end
  end

  // ****************************************
  // AXI4-Lite read channel.
  // ****************************************
  assign s_axi_arready_out = !s_axi_rvalid_out;

  always_comb begin
    rd_ok = 1'b1;
    rd_data = 32'h0000_0000;
    unique case (s_axi_araddr_in)
      CFG_OFS: rd_data = 32'(cfg_reg);
      LUTF_OFS: rd_data = {16'h0000, lutf_q};
      LUTG_OFS: rd_data = {16'h0000, lutg_q};
      LUTH_OFS: rd_data = {24'h00_0000, luth_reg};
      STAT_OFS: rd_data = {24'h00_0000, status};
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0000_0000;
      s_axi_rresp_out <= RESP_OKAY;
    end else if (ce_in) begin
      if (s_axi_arvalid_in && !s_axi_rvalid_out) begin
        s_axi_rvalid_out <= 1'b1;
        s_axi_rdata_out <= rd_data;
        s_axi_rresp_out <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready_in) begin
        s_axi_rvalid_out <= 1'b0;
      end
    end
  end

  // ****************************************
  // Cell clock edges and user memory writes.
  // ****************************************
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cell_clk_prev_reg <= 1'b0;
    end else if (ce_in) begin
      cell_clk_prev_reg <= cell_clk_in;
    end
  end

  assign cell_rise = cell_clk_in && !cell_clk_prev_reg;
  assign cell_fall = !cell_clk_in && cell_clk_prev_reg;
  assign user_we = cfg_reg.mem_en && set_reset_in && cell_rise;
  assign we_f = user_we && !(cfg_reg.mem_32x1 && high_control_input_in);
  assign we_g = user_we && !(cfg_reg.mem_32x1 && !high_control_input_in);
  assign wd_f = low_control_input_in;
  assign wd_g = cfg_reg.mem_32x1 ? low_control_input_in : auxiliary_input_in;

  lcr_lut_ram #(.ADDR_W(4)) u_lut_f (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .load_in(wr_lutf),
    .load_data_in(wr_merged[15:0]),
    .write_in(we_f),
    .waddr_in(table_f_inputs_in),
    .wdata_in(wd_f),
    .raddr_in(table_f_inputs_in),
    .rdata_out(f_lut),
    .contents_out(lutf_q)
  );

  lcr_lut_ram #(.ADDR_W(4)) u_lut_g (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .load_in(wr_lutg),
    .load_data_in(wr_merged[15:0]),
    .write_in(we_g),
    .waddr_in(table_g_inputs_in),
    .wdata_in(wd_g),
    .raddr_in(table_g_inputs_in),
    .rdata_out(g_lut),
    .contents_out(lutg_q)
  );

  // ****************************************
  // Function outputs, carry and counter.
  // ****************************************
  assign cnt_mode = cfg_reg.carry_en && cfg_reg.count_en;
  assign cnt_load = cnt_mode && low_control_input_in;
  assign c_mid = cnt_mode ? (reg_out_first_out && carry_in_in) :
    ((table_f_inputs_in[0] & table_f_inputs_in[1]) |
     (carry_in_in & (table_f_inputs_in[0] ^ table_f_inputs_in[1])));

  always_comb begin
    f_out = f_lut;
    g_out = g_lut;
    carry_out_out = 1'b0;
    if (cnt_load) begin
      f_out = table_f_inputs_in[0];
      g_out = table_g_inputs_in[0];
    end else if (cnt_mode) begin
      f_out = reg_out_first_out ^ carry_in_in;
      g_out = reg_out_second_out ^ c_mid;
      carry_out_out = reg_out_second_out && c_mid;
    end else if (cfg_reg.carry_en) begin
      f_out = table_f_inputs_in[0] ^ table_f_inputs_in[1] ^ carry_in_in;
      g_out = table_g_inputs_in[0] ^ table_g_inputs_in[1] ^ c_mid;
      carry_out_out = (table_g_inputs_in[0] & table_g_inputs_in[1]) |
        (c_mid & (table_g_inputs_in[0] ^ table_g_inputs_in[1]));
    end
  end

  assign h_third = cfg_reg.mem_en ? high_control_input_in : auxiliary_input_in;
  assign h_out = luth_reg[{h_third, g_out, f_out}];
  assign comb_x_out = cfg_reg.x_sel ? h_out : f_out;
  assign comb_y_out = cfg_reg.y_sel ? h_out : g_out;

  // ****************************************
  // Cell flip-flops.
  // ****************************************
  assign sr_act = set_reset_in && !cfg_reg.mem_en;
  assign gsr_all = global_reset_in || gsr_pulse_reg;

  always_comb begin
    unique case (cnt_mode ? SRC_F : cfg_reg.ff1_src)
      SRC_F: d1 = f_out;
      SRC_G: d1 = g_out;
      SRC_H: d1 = h_out;
      SRC_DIN: d1 = low_control_input_in;
    endcase
    unique case (cnt_mode ? SRC_G : cfg_reg.ff2_src)
      SRC_F: d2 = f_out;
      SRC_G: d2 = g_out;
      SRC_H: d2 = h_out;
      SRC_DIN: d2 = low_control_input_in;
    endcase
  end

  lcr_cell_ff u_ff_first (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .tick_in(cfg_reg.ff1_neg ? cell_fall : cell_rise),
    .cell_ce_in(cell_clock_enable_in),
    .d_in(d1),
    .sr_in(sr_act),
    .sr_mode_in(cfg_reg.ff1_sr),
    .gsr_in(gsr_all),
    .init_in(cfg_reg.ff1_init),
    .q_out(reg_out_first_out)
  );

  lcr_cell_ff u_ff_second (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .tick_in(cfg_reg.ff2_neg ? cell_fall : cell_rise),
    .cell_ce_in(cell_clock_enable_in),
    .d_in(d2),
    .sr_in(sr_act),
    .sr_mode_in(cfg_reg.ff2_sr),
    .gsr_in(gsr_all),
    .init_in(cfg_reg.ff2_init),
    .q_out(reg_out_second_out)
  );

  assign status = {h_out, g_out, f_out, carry_out_out, comb_y_out, comb_x_out,
    reg_out_second_out, reg_out_first_out};

  // ****************************************
  // Checks.
  // ****************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence s_count_tick;
    ce_in && cnt_mode && !cnt_load && cell_rise && cell_clock_enable_in &&
      !cfg_reg.ff1_neg && !cfg_reg.ff2_neg && !gsr_all && !sr_act;
  endsequence

  sequence s_count_next;
    {reg_out_second_out, reg_out_first_out} ==
      2'({$past(reg_out_second_out), $past(reg_out_first_out)} + $past(carry_in_in));
  endsequence

  chk_user_write: assert property (
    ce_in && we_f && !wr_lutf |-> ##WR_DLY lutf_q[$past(table_f_inputs_in)] == $past(wd_f))
    else $error("User write did not land in first table.");

  chk_no_strobe: assert property (
    ce_in && !set_reset_in && !wr_lutg |=> $stable(lutg_q))
    else $error("Second table changed without strobe.");

  chk_read_path: assert property (
    cfg_reg.mem_en && !cfg_reg.carry_en && !cfg_reg.x_sel |->
      comb_x_out == lutf_q[table_f_inputs_in])
    else $error("Read data not on X output.");

  chk_fifth_addr: assert property (
    ce_in && user_we && cfg_reg.mem_32x1 && high_control_input_in && !wr_lutf
      |=> $stable(lutf_q))
    else $error("Fifth address bit wrote the wrong table.");

  chk_third_func: assert property (
    cfg_reg.mem_en && !cfg_reg.carry_en && cfg_reg.x_sel |-> comb_x_out == luth_reg[
      {high_control_input_in, lutg_q[table_g_inputs_in], lutf_q[table_f_inputs_in]}])
    else $error("Third table input wrong in memory mode.");

  chk_adder_sum: assert property (
    cfg_reg.carry_en && !cfg_reg.count_en |-> {carry_out_out, g_out, f_out} ==
      3'({table_g_inputs_in[0], table_f_inputs_in[0]} +
         {table_g_inputs_in[1], table_f_inputs_in[1]} + {1'b0, carry_in_in}))
    else $error("Adder slice sum wrong.");

  chk_count_step: assert property (s_count_tick |=> s_count_next)
    else $error("Counter did not advance by carry.");

  chk_global_set: assert property (
    ce_in && gsr_all |=> reg_out_first_out == $past(cfg_reg.ff1_init))
    else $error("Global reset did not force programmed state.");

  chk_async_set: assert property (
    ce_in && sr_act && cfg_reg.ff1_sr == SR_SET && !gsr_all |=> reg_out_first_out)
    else $error("Set did not force first flop high.");

  chk_ff_hold: assert property (
    ce_in && !cell_rise && !cell_fall && !sr_act && !gsr_all |=> $stable(reg_out_first_out))
    else $error("First flop changed without a cell clock edge.");

  chk_mode_sr: assert property (
    ce_in && cfg_reg.mem_en && !gsr_all && !cell_rise && !cell_fall
      |=> $stable(reg_out_second_out))
    else $error("Write strobe disturbed a flop in memory mode.");

endmodule

// [test/lcr_user_model.sv]
`timescale 1ns/1ps
// ****************************************
// User logic on the far side of the cell.
// ****************************************
module lcr_user_model (
  input wire logic clk_in,
  output logic [3:0] f_out,
  output logic [3:0] g_out,
  output logic aux_out,
  output logic hi_out,
  output logic lo_out,
  output logic sr_out,
  output logic kclk_out,
  output logic kce_out,
  output logic gr_out,
  output logic cin_out
);
  initial begin
    {f_out, g_out, aux_out, hi_out, lo_out, sr_out} = '0;
    {kclk_out, kce_out, gr_out, cin_out} = '0;
  end
  // Address, data and strobe change just after an edge and stay put.
  task put(input logic [3:0] f, input logic [3:0] g, input logic aux, input logic hi,
           input logic lo, input logic sr, input logic ce, input logic gr, input logic cin);
    @(posedge clk_in);
    f_out <= f;
    g_out <= g;
    {aux_out, lo_out, sr_out} <= {aux, lo, sr};
    hi_out <= hi;
    {kce_out, gr_out, cin_out} <= {ce, gr, cin};
  endtask
  // Each cell clock level lasts at least three system clocks.
  task edge_to(input logic lvl);
    @(posedge clk_in);
    kclk_out <= lvl;
    repeat (2) @(posedge clk_in);
  endtask
endmodule

// [test/tb.sv]
`timescale 1ns/1ps
module tb;
  import lcr_pkg::*;
  logic clk_in = 0;
  logic rst_in = 1;
  logic ce = 1;
  logic [7:0] awaddr = '0;
  logic [7:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, cout, cx, cy, q1, q2;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [3:0] f, g, fp, gp, wstrb = 4'hF;
  logic aux, hi, lo, sr, kclk, kce, gr, cin, b, e1, e2;
  logic [15:0] mf, mg;
  logic [7:0] lh;
  logic [1:0] cnt, c1;
  int seed = 32'h1746553d;
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;
  always #25 clk_in = ~clk_in;
  lcr_user_model u_user (.clk_in(clk_in), .f_out(fp), .g_out(gp), .aux_out(aux), .hi_out(hi),
    .lo_out(lo), .sr_out(sr), .kclk_out(kclk), .kce_out(kce), .gr_out(gr), .cin_out(cin));
  lcr_cell dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce), .table_f_inputs_in(fp),
    .table_g_inputs_in(gp), .auxiliary_input_in(aux), .high_control_input_in(hi),
    .low_control_input_in(lo), .set_reset_in(sr), .cell_clk_in(kclk),
    .cell_clock_enable_in(kce), .global_reset_in(gr), .carry_in_in(cin),
    .carry_out_out(cout), .comb_x_out(cx), .comb_y_out(cy), .reg_out_first_out(q1),
    .reg_out_second_out(q2), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb),
    .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
    .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready));
  // ****************************************
  // Shared tasks.
  // ****************************************
  task check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task close_out;
    if (bad_count == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk_in);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_in);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    check(32'(bresp), 32'(er));
    bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_in);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    check(32'(rresp), 32'(er));
    if (er === RESP_OKAY) check(rdata, ed);
    rready <= 1'b0;
  endtask
  task settle;
    @(posedge clk_in);
    #1;
  endtask
  task cell_pulse;
    u_user.edge_to(1'b1);
    u_user.edge_to(1'b0);
  endtask
  function automatic logic maj(input logic x, input logic y, input logic z);
    return (x & y) | (x & z) | (y & z);
  endfunction
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      bad_count++;
      close_out();
    end
  end
  // ****************************************
  // Main sequence.
  // ****************************************
  initial begin
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(CFG_OFS, CFG_RESET, RESP_OKAY);
    rd(LUTG_OFS, 32'(LUT_RESET), RESP_OKAY);
    rd(8'h14, 32'h0, RESP_SLVERR);
    wr(8'h14, 32'h1, RESP_SLVERR);
    wr(STAT_OFS, 32'hFF, RESP_SLVERR);
    wr(CFG_OFS, 32'hFFFFFFFF, RESP_OKAY);
    rd(CFG_OFS, 32'h0003FFFF, RESP_OKAY);
    mf = 16'($random(seed));
    mg = 16'($random(seed));
    lh = 8'($random(seed));
    wr(LUTF_OFS, 32'(mf), RESP_OKAY);
    wr(LUTG_OFS, 32'(mg), RESP_OKAY);
    wr(LUTH_OFS, {24'hFFFFFF, lh}, RESP_OKAY);
    rd(LUTH_OFS, 32'(lh), RESP_OKAY);
    wstrb <= 4'h2;
    wr(LUTF_OFS, 32'(~mf), RESP_OKAY);
    wstrb <= 4'hF;
    mf[15:8] = ~mf[15:8];
    rd(LUTF_OFS, 32'(mf), RESP_OKAY);
    wr(CFG_OFS, 32'h11, RESP_OKAY);
    for (int i = 0; i < 8; i++) begin
      {b, e1, e2} = 3'($random(seed));
      f = (i == 0) ? 4'h0 : ((i == 1) ? 4'hF : 4'($random(seed)));
      g = (i == 0) ? 4'hF : 4'($random(seed));
      u_user.put(f, g, e1, e2, b, 1'b1, 1'b1, 1'b0, 1'b0);
      cell_pulse();
      mf[f] = b;
      mg[g] = e1;
    end
    u_user.put(4'h3, 4'h3, ~mg[3], 1'b0, ~mf[3], 1'b0, 1'b1, 1'b0, 1'b0);
    cell_pulse();
    for (int i = 0; i < 16; i++) begin
      b = 1'($random(seed));
      u_user.put(4'(i), 4'(i), 1'b0, b, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
      settle();
      check(32'({cy, cx}), 32'({mg[i], lh[{b, mg[i], mf[i]}]}));
    end
    rd(LUTF_OFS, 32'(mf), RESP_OKAY);
    rd(LUTG_OFS, 32'(mg), RESP_OKAY);
    wr(CFG_OFS, 32'h3, RESP_OKAY);
    for (int i = 0; i < 8; i++) begin
      {b, e2} = 2'($random(seed));
      f = 4'($random(seed));
      g = 4'($random(seed));
      u_user.put(f, g, ~b, e2, b, 1'b1, 1'b1, 1'b0, 1'b0);
      cell_pulse();
      if (e2) mg[g] = b;
      else mf[f] = b;
    end
    rd(LUTF_OFS, 32'(mf), RESP_OKAY);
    rd(LUTG_OFS, 32'(mg), RESP_OKAY);
    wr(CFG_OFS, 32'h11BC0, RESP_OKAY);
    u_user.put(4'h0, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
    settle();
    check(32'({q2, q1}), 32'h1);
    {e2, e1} = 2'h1;
    for (int i = 0; i < 6; i++) begin
      b = (i == 5) ? 1'b0 : 1'($random(seed));
      f = 4'($random(seed));
      u_user.put(f, 4'h0, 1'b0, 1'b0, b, 1'b0, i != 3, 1'b0, 1'b0);
      settle();
      check(32'(cx), 32'(mf[f]));
      u_user.edge_to(1'b1);
      #1;
      e1 = (i != 3) ? b : e1;
      check(32'({q2, q1}), 32'({e2, e1}));
      u_user.edge_to(1'b0);
      #1;
      e2 = (i != 3) ? b : e2;
      check(32'({q2, q1}), 32'({e2, e1}));
    end
    u_user.put(4'h0, 4'h0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
    settle();
    check(32'({q2, q1}), 32'({e2, 1'b1}));
    wr(CFG_OFS, 32'h4, RESP_OKAY);
    for (int i = 0; i < 8; i++) begin
      f = 4'($random(seed));
      g = 4'($random(seed));
      b = 1'($random(seed));
      u_user.put(f, g, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, b);
      settle();
      c1 = {f[0] ^ f[1] ^ b, maj(f[0], f[1], b)};
      e1 = g[0] ^ g[1] ^ c1[0];
      check(32'({cout, cy, cx}), 32'({maj(g[0], g[1], c1[0]), e1, c1[1]}));
    end
    wr(CFG_OFS, 32'hC, RESP_OKAY);
    f = 4'($random(seed));
    g = 4'($random(seed));
    u_user.put(f, g, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    cell_pulse();
    cnt = {g[0], f[0]};
    check(32'({q2, q1}), 32'(cnt));
    u_user.put(f, g, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
    for (int i = 0; i < 5; i++) begin
      settle();
      check(32'(cout), 32'(&cnt));
      cell_pulse();
      #1;
      cnt = cnt + 2'h1;
      check(32'({q2, q1}), 32'(cnt));
    end
    @(posedge clk_in);
    ce <= 1'b0;
    cell_pulse();
    @(posedge clk_in);
    ce <= 1'b1;
    settle();
    check(32'({q2, q1}), 32'(cnt));
    close_out();
  end
endmodule
